// File: include/idw_defines.svh
// Offsets, field positions, reset values and timing counts of the isolated digital I/O block
`ifndef IDW_DEFINES_SVH
`define IDW_DEFINES_SVH

// ==========================================
// Direct host offsets (byte offsets)
`define IDW_OFS_AUX 3'h1
`define IDW_OFS_INP 3'h3
`define IDW_OFS_OUT 3'h5
`define IDW_OFS_CSR 3'h7

// ==========================================
// Indirect register pointers
`define IDW_PTR_MIC 6'h00
`define IDW_PTR_MCFG 6'h01
`define IDW_PTR_AUX_DIR 6'h06
`define IDW_PTR_INP_PEND 6'h09
`define IDW_PTR_T3CMD 6'h0C
`define IDW_PTR_OUTD 6'h0D
`define IDW_PTR_INPD 6'h0E
`define IDW_PTR_AUXD 6'h0F
`define IDW_PTR_T3CNT_HI 6'h14
`define IDW_PTR_T3CNT_LO 6'h15
`define IDW_PTR_T3PRE_HI 6'h1A
`define IDW_PTR_T3PRE_LO 6'h1B
`define IDW_PTR_T3MODE 6'h1E
`define IDW_PTR_INP_POL 6'h2A
`define IDW_PTR_INP_DIR 6'h2B
`define IDW_PTR_RISE_EN 6'h2D
`define IDW_PTR_FALL_EN 6'h2E

// ==========================================
// Field positions
`define IDW_MIC_RESET 0
`define IDW_MIC_IRQ_EN 7
`define IDW_MCFG_OUT_EN 2
`define IDW_MCFG_T3_EN 4
`define IDW_MCFG_INP_EN 7
`define IDW_T3MODE_RETRIG 2
`define IDW_T3MODE_CONT 7
`define IDW_T3CMD_RUN 0
`define IDW_T3CMD_TRIG 1
`define IDW_T3CMD_GATE 2
`define IDW_AUX_RETRIG_BIT 2
`define IDW_AUX_WDOG_BIT 3

// ==========================================
// Reset values
`define IDW_MIC_RST 8'h01
`define IDW_AUX_DATA_RST 4'hF
`define IDW_ZERO_RST 8'h00

// ==========================================
// Timing
`define IDW_CLK_NS 25
`define IDW_DEBOUNCE_NS 12000000
`define IDW_DEBOUNCE_CYC (`IDW_DEBOUNCE_NS / `IDW_CLK_NS)
`define IDW_WDOG_MAX_NS 30000000
`define IDW_T3_FULL 61440
`define IDW_T3_TICK_CYC ((`IDW_WDOG_MAX_NS / `IDW_T3_FULL) / `IDW_CLK_NS)

`endif

// File: include/idw_pkg.sv
// Types shared by the isolated digital I/O block
package idw_pkg;

    // ==========================================
    // Indirect access pointer state, one-hot
    typedef enum logic [2:0] {
        idw_st_reset = 3'b001,
        idw_st_ptr = 3'b010,
        idw_st_data = 3'b100
    } idw_ptr_state_t;

endpackage

// File: verilog/idw_debounce.sv
// Per-channel input synchroniser and debounce filter
`timescale 1ns/100ps
module idw_debounce #(
    parameter int WIDTH = 8,
    parameter int CYCLES = 480000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] filt_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    // ==========================================
    // One filter per channel
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_ch
            logic sync0;
            logic sync1;
            logic [CW-1:0] cnt;

            // Two flops before anything looks at the pin
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync0 <= 1'b0;
                    sync1 <= 1'b0;
                end else if (ce) begin
                    sync0 <= raw_in[i];
                    sync1 <= sync0;
                end
            end

            // New level must hold for the full period; any bounce restarts it
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cnt <= '0;
                    filt_out[i] <= 1'b0;
                end else if (ce) begin
                    if (sync1 == filt_out[i]) begin
                        cnt <= '0;
                    end else if (cnt == LAST) begin
                        cnt <= '0;
                        filt_out[i] <= sync1;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

// File: verilog/idw_top.sv
// Isolated digital I/O with debounced inputs, edge interrupts and output watchdog
`timescale 1ns/100ps
`include "idw_defines.svh"
module idw_top #(
    parameter int CHANNELS = 8,
    parameter int DEBOUNCE_CYCLES = `IDW_DEBOUNCE_CYC,
    parameter int T3_TICK_CYCLES = `IDW_T3_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic host_req,
    input wire logic host_wr,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_ack,
    input wire logic [CHANNELS-1:0] raw_in,
    input wire logic [CHANNELS-1:0] fault_in,
    output logic [CHANNELS-1:0] out_drive,
    output logic irq_n,
    output logic wdog_expired
);
    localparam int TW = $clog2(T3_TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(T3_TICK_CYCLES - 1);

    // ==========================================
    // Declarations
    idw_pkg::idw_ptr_state_t ptr_state;
    logic [5:0] pointer;
    logic [7:0] master_interrupt_control;
    logic [7:0] master_config_reg;
    logic [7:0] output_port_data;
    logic [7:0] input_port_latch;
    logic [7:0] input_port_direction;
    logic [7:0] input_port_polarity;
    logic [7:0] input_rise_irq_en;
    logic [7:0] input_fall_irq_en;
    logic [7:0] input_irq_pending;
    logic [3:0] aux_port_data;
    logic [3:0] aux_port_mask;
    logic [3:0] aux_port_direction;
    logic [7:0] timer3_mode_reg;
    logic [7:0] timer3_preload_high;
    logic [7:0] timer3_preload_low;
    logic timer3_gate;
    logic timer3_run;
    logic [15:0] timer3_count;
    logic [TW-1:0] tick_cnt;
    logic [CHANNELS-1:0] filt;
    logic [7:0] filt8;
    logic [7:0] fault8;
    logic [CHANNELS-1:0] fault_s0;
    logic [CHANNELS-1:0] fault_s1;
    logic [7:0] input_prev;
    logic [7:0] input_port_data;
    logic [7:0] ind_rdata;
    logic [7:0] next_out;
    logic acc;
    logic acc_csr;
    logic in_reset;
    logic ind_wr;
    logic wr_out;
    logic wr_inp;
    logic wr_aux;
    logic out_en;
    logic inp_en;
    logic t3_en;
    logic wdog_active;
    logic retrig;
    logic t3_trig;
    logic t3_done;

    // ==========================================
    // Access decode
    assign acc = ce & host_req;
    assign acc_csr = acc & (host_addr == `IDW_OFS_CSR);
    assign in_reset = (ptr_state == idw_pkg::idw_st_reset);
    assign ind_wr = acc_csr & host_wr & (ptr_state == idw_pkg::idw_st_data);
    assign wr_out = (acc & host_wr & (host_addr == `IDW_OFS_OUT))
        | (ind_wr & (pointer == `IDW_PTR_OUTD));
    assign wr_inp = (acc & host_wr & (host_addr == `IDW_OFS_INP))
        | (ind_wr & (pointer == `IDW_PTR_INPD));
    assign wr_aux = acc & host_wr & (host_addr == `IDW_OFS_AUX);
    assign out_en = master_config_reg[`IDW_MCFG_OUT_EN];
    assign inp_en = master_config_reg[`IDW_MCFG_INP_EN];
    assign t3_en = master_config_reg[`IDW_MCFG_T3_EN];

    // With timer 3 enabled, aux bit 3 low, as output, with bit 2 as retrigger input arms the watchdog
    assign wdog_active = t3_en & aux_port_direction[`IDW_AUX_RETRIG_BIT]
        & ~aux_port_direction[`IDW_AUX_WDOG_BIT]
        & ~aux_port_data[`IDW_AUX_WDOG_BIT];
    // Every access, direct or indirect, is a retrigger while armed and the timer 3 mode retrigger bit is set
    assign retrig = acc & wdog_active & timer3_mode_reg[`IDW_T3MODE_RETRIG];
    assign t3_trig = retrig
        | (ind_wr & (pointer == `IDW_PTR_T3CMD) & host_wdata[`IDW_T3CMD_TRIG]);
    assign t3_done = timer3_run & timer3_gate & t3_en & (tick_cnt == TICK_LAST)
        & (timer3_count <= 16'h0001);

    // ==========================================
    // Input filtering and port widening
    idw_debounce #(
        .WIDTH(CHANNELS),
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .raw_in(raw_in),
        .filt_out(filt)
    );

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            if (i < CHANNELS) begin : g_ch
                assign filt8[i] = filt[i];
                assign fault8[i] = fault_s1[i];
            end else begin : g_none
                assign filt8[i] = 1'b0;
                assign fault8[i] = 1'b0;
            end
            // Input bits show the filtered level, output bits the latch
            assign input_port_data[i] = input_port_direction[i]
                ? (filt8[i] ^ input_port_polarity[i]) : input_port_latch[i];
        end
    endgenerate

    // Driver fault flags come from another domain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_s0 <= '0;
            fault_s1 <= '0;
        end else if (ce) begin
            fault_s0 <= fault_in;
            fault_s1 <= fault_s0;
        end
    end

    // ==========================================
    // Pointer state machine
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ptr_state <= idw_pkg::idw_st_reset;
            pointer <= 6'h00;
        end else if (acc_csr) begin
            case (ptr_state)
                idw_pkg::idw_st_reset: begin
                    if (host_wr && !host_wdata[`IDW_MIC_RESET]) begin
                        ptr_state <= idw_pkg::idw_st_ptr;
                    end
                end
                idw_pkg::idw_st_ptr: begin
                    if (host_wr) begin
                        pointer <= host_wdata[5:0];
                        ptr_state <= idw_pkg::idw_st_data;
                    end
                end
                idw_pkg::idw_st_data: begin
                    // Setting the reset bit returns the controller to reset
                    if (host_wr && pointer == `IDW_PTR_MIC && host_wdata[`IDW_MIC_RESET]) begin
                        ptr_state <= idw_pkg::idw_st_reset;
                    end else begin
                        ptr_state <= idw_pkg::idw_st_ptr;
                    end
                end
                default: begin
                    ptr_state <= idw_pkg::idw_st_reset;
                end
            endcase
        end
    end

    // ==========================================
    // Configuration registers; the reset state holds them all at defaults
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            master_interrupt_control <= `IDW_MIC_RST;
            master_config_reg <= `IDW_ZERO_RST;
            input_port_direction <= `IDW_ZERO_RST;
            input_port_polarity <= `IDW_ZERO_RST;
            input_rise_irq_en <= `IDW_ZERO_RST;
            input_fall_irq_en <= `IDW_ZERO_RST;
            timer3_mode_reg <= `IDW_ZERO_RST;
            timer3_preload_high <= `IDW_ZERO_RST;
            timer3_preload_low <= `IDW_ZERO_RST;
            aux_port_direction <= 4'h0;
        end else if (ind_wr) begin
            case (pointer)
                `IDW_PTR_MIC: master_interrupt_control <= host_wdata;
                `IDW_PTR_MCFG: master_config_reg <= host_wdata;
                `IDW_PTR_INP_DIR: input_port_direction <= host_wdata;
                `IDW_PTR_INP_POL: input_port_polarity <= host_wdata;
                `IDW_PTR_RISE_EN: input_rise_irq_en <= host_wdata;
                `IDW_PTR_FALL_EN: input_fall_irq_en <= host_wdata;
                `IDW_PTR_T3MODE: timer3_mode_reg <= host_wdata;
                `IDW_PTR_T3PRE_HI: timer3_preload_high <= host_wdata;
                `IDW_PTR_T3PRE_LO: timer3_preload_low <= host_wdata;
                `IDW_PTR_AUX_DIR: aux_port_direction <= host_wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Port data latches; output data is never touched by the watchdog
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            output_port_data <= `IDW_ZERO_RST;
            input_port_latch <= `IDW_ZERO_RST;
        end else begin
            if (wr_out) begin
                output_port_data <= host_wdata;
            end
            if (wr_inp) begin
                input_port_latch <= host_wdata;
            end
        end
    end

    // Aux port: upper nibble of the indirect write protects lower bits
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            aux_port_data <= `IDW_AUX_DATA_RST;
            aux_port_mask <= 4'h0;
        end else if (ind_wr && pointer == `IDW_PTR_AUXD) begin
            aux_port_mask <= host_wdata[7:4];
            aux_port_data <= (aux_port_data & host_wdata[7:4])
                | (host_wdata[3:0] & ~host_wdata[7:4]);
        end else if (wr_aux) begin
            aux_port_data <= (aux_port_data & (aux_port_mask | aux_port_direction))
                | (host_wdata[3:0] & ~(aux_port_mask | aux_port_direction));
        end
    end

    // ==========================================
    // Timer 3 gate and trigger
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            timer3_gate <= 1'b0;
        end else if (ind_wr && pointer == `IDW_PTR_T3CMD) begin
            timer3_gate <= host_wdata[`IDW_T3CMD_GATE];
        end
    end

    // Down counter; prescaler sets the count period so 0xF000 is about 30 ms
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            timer3_run <= 1'b0;
            timer3_count <= 16'h0000;
            tick_cnt <= '0;
        end else if (ce) begin
            if (t3_trig && t3_en) begin
                timer3_count <= {timer3_preload_high, timer3_preload_low};
                timer3_run <= 1'b1;
                tick_cnt <= '0;
            end else if (timer3_run && timer3_gate && t3_en) begin
                if (tick_cnt == TICK_LAST) begin
                    tick_cnt <= '0;
                    if (t3_done) begin
                        timer3_count <= timer3_mode_reg[`IDW_T3MODE_CONT]
                            ? {timer3_preload_high, timer3_preload_low} : 16'h0000;
                        timer3_run <= timer3_mode_reg[`IDW_T3MODE_CONT];
                    end else begin
                        timer3_count <= timer3_count - 16'h0001;
                    end
                end else begin
                    tick_cnt <= tick_cnt + 1'b1;
                end
            end
        end
    end

    // Expiry flag: a retriggering access clears it and wins over expiry
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            wdog_expired <= 1'b0;
        end else if (ce) begin
            if (retrig) begin
                wdog_expired <= 1'b0;
            end else if (t3_done && wdog_active) begin
                wdog_expired <= 1'b1;
            end
        end
    end

    // ==========================================
    // Output drive: enable, per-channel fault and watchdog gating
    assign next_out = (out_en && !(wdog_active && wdog_expired))
        ? (output_port_data & ~fault8) : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_drive <= '0;
        end else if (ce) begin
            out_drive <= next_out[CHANNELS-1:0];
        end
    end

    // ==========================================
    // Edge interrupts; a new edge beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && in_reset)) begin
            input_prev <= 8'h00;
            input_irq_pending <= 8'h00;
        end else if (ce) begin
            input_prev <= input_port_data;
            input_irq_pending <= (input_irq_pending
                & ~((ind_wr && pointer == `IDW_PTR_INP_PEND) ? host_wdata : 8'h00))
                | ({8{inp_en}} & input_port_direction
                & ((input_port_data & ~input_prev & input_rise_irq_en)
                | (~input_port_data & input_prev & input_fall_irq_en)));
        end
    end

    // One shared active-low request line
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else if (ce) begin
            irq_n <= ~(master_interrupt_control[`IDW_MIC_IRQ_EN]
                & (|input_irq_pending));
        end
    end

    // ==========================================
    // Indirect read selection; unlisted pointers read zero
    always_comb begin
        case (pointer)
            `IDW_PTR_MIC: ind_rdata = master_interrupt_control;
            `IDW_PTR_MCFG: ind_rdata = master_config_reg;
            `IDW_PTR_AUX_DIR: ind_rdata = {4'h0, aux_port_direction};
            `IDW_PTR_INP_PEND: ind_rdata = input_irq_pending;
            `IDW_PTR_T3CMD: ind_rdata = {5'h00, timer3_gate, 1'b0, timer3_run};
            `IDW_PTR_OUTD: ind_rdata = output_port_data;
            `IDW_PTR_INPD: ind_rdata = inp_en ? input_port_data : 8'h00;
            `IDW_PTR_AUXD: ind_rdata = {aux_port_mask, aux_port_data};
            `IDW_PTR_T3CNT_HI: ind_rdata = timer3_count[15:8];
            `IDW_PTR_T3CNT_LO: ind_rdata = timer3_count[7:0];
            `IDW_PTR_T3PRE_HI: ind_rdata = timer3_preload_high;
            `IDW_PTR_T3PRE_LO: ind_rdata = timer3_preload_low;
            `IDW_PTR_T3MODE: ind_rdata = timer3_mode_reg;
            `IDW_PTR_INP_POL: ind_rdata = input_port_polarity;
            `IDW_PTR_INP_DIR: ind_rdata = input_port_direction;
            `IDW_PTR_RISE_EN: ind_rdata = input_rise_irq_en;
            `IDW_PTR_FALL_EN: ind_rdata = input_fall_irq_en;
            default: ind_rdata = 8'h00;
        endcase
    end

    // ==========================================
    // Host answer: data and acknowledge one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_rdata <= 8'h00;
            host_ack <= 1'b0;
        end else if (ce) begin
            host_ack <= host_req;
            if (host_req && !host_wr) begin
                case (host_addr)
                    `IDW_OFS_AUX: host_rdata <= {aux_port_mask, aux_port_data};
                    `IDW_OFS_INP: host_rdata <= inp_en ? input_port_data : 8'h00;
                    `IDW_OFS_OUT: host_rdata <= output_port_data;
                    `IDW_OFS_CSR: host_rdata <= in_reset ? master_interrupt_control : ind_rdata;
                    default: host_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// File: dv/idw_top_monitor.sv
// Port checker of the isolated digital I/O block
`timescale 1ns/100ps
module idw_top_monitor #(parameter int CHANNELS = 8) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic host_req,
    input wire logic host_wr,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_rdata,
    input wire logic host_ack,
    input wire logic [CHANNELS-1:0] fault_in,
    input wire logic [CHANNELS-1:0] out_drive,
    input wire logic irq_n,
    input wire logic wdog_expired
);
    // ==========
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ack_follows: assert property (ce && host_req |=> host_ack)
        else $error("ack missing");
    a_ack_spurious: assert property (!(ce && host_req) |=> !host_ack)
        else $error("ack without request");
    a_even_zero: assert property (ce && host_req && !host_wr && !host_addr[0]
        |=> host_rdata == 8'h00) else $error("even offset read not zero");
    a_rdata_holds: assert property (!(ce && host_req && !host_wr)
        |=> $stable(host_rdata)) else $error("read data moved");
    a_expiry_gates: assert property ((wdog_expired) [*2] |-> out_drive == '0)
        else $error("outputs driven after expiry");
    // Clock enable low freezes the sync flops, so only enabled cycles count
    a_fault_gates: assert property ((ce && fault_in == '1) [*4] |-> out_drive == '0)
        else $error("faulted output driven");
    a_access_clears: assert property (wdog_expired && ce && host_req
        |-> ##[1:2] !wdog_expired) else $error("access did not clear expiry");
    a_retrig_window: assert property ($rose(wdog_expired)
        |-> !$past(host_req) && !$past(host_req, 2)) else $error("expiry after access");
    a_reset_quiet: assert property (disable iff (1'b0) rst
        |=> out_drive == '0 && irq_n && !wdog_expired) else $error("reset state wrong");
    // Main scenarios reached
    c_irq: cover property (!irq_n);
    c_expiry: cover property ($rose(wdog_expired));
    c_fault: cover property ((fault_in == '1) [*4]);
endmodule

// File: dv/idw_host_model.sv
// Host bus model issuing single and indirect register accesses
`timescale 1ns/100ps
module idw_host_model (
    input wire logic ref_clk,
    input wire logic host_ack,
    output logic host_req,
    output logic host_wr,
    output logic [2:0] host_addr,
    output logic [7:0] host_wdata
);
    logic [8:0] note_q[$];
    // ==========
    // Bus idle until the first access
    initial begin
        host_req = 1'b0;
        host_wr = 1'b0;
        host_addr = 3'h0;
        host_wdata = 8'h00;
    end
    // One-cycle request pulse; read notes carry the expected data
    task automatic acc(input logic wr, input logic [2:0] addr, input logic [7:0] d);
        @(negedge ref_clk);
        host_req = 1'b1;
        host_wr = wr;
        host_addr = addr;
        host_wdata = d;
        note_q.push_back({~wr, d});
        @(negedge ref_clk);
        host_req = 1'b0;
        host_wdata = ~d; // Released data must not look valid
        @(negedge ref_clk);
    endtask
    // Pointer write then data write through the command/status offset
    task automatic ind(input logic [7:0] p, input logic [7:0] v);
        acc(1'b1, 3'h7, p);
        acc(1'b1, 3'h7, v);
    endtask
endmodule

// File: dv/idw_top_tb.sv
// Self-checking bench of the isolated digital I/O block
`timescale 1ns/100ps
module idw_top_tb;
    localparam int DEB = 8;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] raw_in = 8'h00;
    logic [7:0] fault_in = 8'h00;
    wire logic host_req, host_wr, host_ack, irq_n, wdog_expired;
    wire logic [2:0] host_addr;
    wire logic [7:0] host_wdata, host_rdata, out_drive;
    int error_cnt = 0;
    int compares = 0;
    int i;
    logic [7:0] v, f;
    logic [8:0] n;
    always #12.5 ref_clk = ~ref_clk;
    idw_top #(.DEBOUNCE_CYCLES(DEB), .T3_TICK_CYCLES(1)) u_dut (.ref_clk, .rst, .ce,
        .host_req, .host_wr, .host_addr, .host_wdata, .host_rdata, .host_ack, .raw_in,
        .fault_in, .out_drive, .irq_n, .wdog_expired);
    idw_host_model u_host (.ref_clk, .host_ack, .host_req, .host_wr, .host_addr, .host_wdata);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Inputs settle past the filter before anything is judged
    task automatic put(input logic [7:0] r);
        raw_in = r;
        repeat (DEB + 6) @(negedge ref_clk);
    endtask
    // Each acknowledge retires the oldest note; read notes are compared
    always @(negedge ref_clk) begin
        if (host_ack === 1'b1 && u_host.note_q.size() > 0) begin
            n = u_host.note_q.pop_front();
            if (n[8]) check(host_rdata, n[7:0]);
        end
    end
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
    // ==========
    // Main sequence
    initial begin
        v = $urandom(32'h8024F1B2);
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        check(out_drive, 8'h00);
        check({6'h00, wdog_expired, irq_n}, 8'h01);
        u_host.acc(1'b0, 3'h7, 8'h01);
        u_host.acc(1'b0, 3'h3, 8'h00);
        u_host.acc(1'b0, 3'h2, 8'h00);
        u_host.acc(1'b1, 3'h7, 8'h00);
        u_host.acc(1'b1, 3'h7, 8'h01);
        u_host.acc(1'b1, 3'h7, 8'h00);
        u_host.ind(8'h2B, 8'hFF);
        u_host.ind(8'h2A, 8'hFF);
        u_host.ind(8'h01, 8'h84);
        u_host.ind(8'h00, 8'h80);
        u_host.ind(8'h2D, 8'hFF);
        // Data state read, then a pointer state read of the same register
        u_host.acc(1'b1, 3'h7, 8'h2B);
        u_host.acc(1'b0, 3'h7, 8'hFF);
        u_host.acc(1'b0, 3'h7, 8'hFF);
        $display("Test reset and init done");
        for (i = 0; i < 6; i++) begin
            v = $urandom;
            put(v);
            u_host.acc(1'b0, 3'h3, ~v);
            raw_in = ~v;
            repeat (DEB - 2) @(negedge ref_clk);
            put(v);
            u_host.acc(1'b0, 3'h3, ~v);
        end
        put(8'hFF);
        put(8'h00);
        check({7'h00, irq_n}, 8'h00);
        u_host.ind(8'h2D, 8'h00);
        u_host.ind(8'h2E, 8'hFF);
        u_host.ind(8'h09, 8'hFF);
        check({7'h00, irq_n}, 8'h01);
        put(8'hFF);
        check({7'h00, irq_n}, 8'h00);
        u_host.ind(8'h09, 8'hFF);
        put(8'h00);
        check({7'h00, irq_n}, 8'h01);
        $display("Test inputs done");
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            f = (i == 0) ? 8'hFF : 8'($urandom);
            fault_in = f;
            u_host.acc(1'b1, 3'h5, v);
            repeat (4) @(negedge ref_clk);
            check(out_drive, v & ~f);
        end
        // Clock enable low: new faults must not reach the frozen outputs
        ce = 1'b0;
        fault_in = ~f;
        repeat (6) @(negedge ref_clk);
        check(out_drive, v & ~f);
        ce = 1'b1;
        fault_in = 8'h00;
        $display("Test outputs done");
        u_host.ind(8'h1E, 8'h55);
        u_host.ind(8'h1A, 8'h00);
        u_host.ind(8'h1B, 8'h10);
        u_host.ind(8'h06, 8'h04);
        u_host.ind(8'h01, 8'h94);
        u_host.ind(8'h0F, 8'h70);
        u_host.ind(8'h0C, 8'h06);
        u_host.acc(1'b1, 3'h1, 8'h00);
        u_host.acc(1'b1, 3'h5, 8'hA5);
        for (i = 0; i < 6; i++) begin
            repeat (8) @(negedge ref_clk);
            u_host.acc(1'b0, 3'h0, 8'h00);
            check({wdog_expired, out_drive[6:0]}, 8'h25);
        end
        i = 0;
        while (wdog_expired !== 1'b1 && i < 200) begin
            @(negedge ref_clk);
            i++;
        end
        @(negedge ref_clk);
        check({wdog_expired, out_drive[6:0]}, 8'h80);
        // Preload 16 ticks of one cycle; the wait starts 1.5 cycles after the trigger
        check(8'(i), 8'h0F);
        u_host.acc(1'b0, 3'h0, 8'h00);
        check({wdog_expired, out_drive[6:0]}, 8'h25);
        $display("Test watchdog done");
        // Second reset in mid-run: watchdog and ports must stay off afterwards
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (30) @(negedge ref_clk);
        check({7'h00, wdog_expired}, 8'h00);
        check(out_drive, 8'h00);
        u_host.acc(1'b0, 3'h7, 8'h01);
        $display("Test second reset done");
        finish_test();
    end
endmodule
bind idw_top idw_top_monitor #(.CHANNELS(CHANNELS)) u_mon (.ref_clk, .rst, .ce, .host_req,
    .host_wr, .host_addr, .host_rdata, .host_ack, .fault_in, .out_drive, .irq_n, .wdog_expired);
